// [design/dpsb_pkg.sv]
package dpsb_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned DEPTH = 64;
  localparam int unsigned BYTE_AW = 5;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } dpsb_rd_req_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dpsb_wr_req_t;

  typedef struct packed {
    logic rclk;
    logic wclk;
    dpsb_rd_req_t rd;
    dpsb_wr_req_t wr;
  } dpsb_pins_t;

  localparam int unsigned PINS_W = $bits(dpsb_pins_t);

  typedef struct packed {
    logic [DEPTH-1:0][NIB_W-1:0] mem;
    logic rclk_prev;
    logic wclk_prev;
    logic [DATA_W-1:0] rdata;
    logic rdone;
    logic wdone;
  } dpsb_state_t;

endpackage : dpsb_pkg

// [design/dpsb_sync.sv]
`timescale 1ns/100ps
module dpsb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] filt_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } dpsb_sync_st_t;

  dpsb_sync_st_t st_r;
  dpsb_sync_st_t st_nxt;

  // The first stage feeds only the second; each bit settles once stages two and three agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filt_out = st_r.filt;

endmodule : dpsb_sync

// [design/dpsb_top.sv]
`timescale 1ns/100ps
module dpsb_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic byte_mode,
  input wire logic read_clk_pol,
  input wire logic write_clk_pol,
  input wire logic read_clk,
  input wire logic write_clk,
  input wire logic [dpsb_pkg::ADDR_W-1:0] read_addr,
  input wire logic [dpsb_pkg::ADDR_W-1:0] write_addr,
  input wire logic [dpsb_pkg::DATA_W-1:0] write_data_in,
  input wire logic write_en,
  output logic [dpsb_pkg::DATA_W-1:0] read_data_out,
  output logic read_done,
  output logic write_done
);

  dpsb_pkg::dpsb_pins_t pins_raw;
  dpsb_pkg::dpsb_pins_t pins_f;
  dpsb_pkg::dpsb_state_t st_r;
  dpsb_pkg::dpsb_state_t st_nxt;
  logic rd_fire;
  logic wr_fire;
  logic [dpsb_pkg::DATA_W-1:0] rd_word;
  logic [dpsb_pkg::ADDR_W-1:0] rd_lo_idx;
  logic [dpsb_pkg::ADDR_W-1:0] rd_hi_idx;
  logic [dpsb_pkg::ADDR_W-1:0] wr_lo_idx;
  logic [dpsb_pkg::ADDR_W-1:0] wr_hi_idx;

  // Clocks, addresses, data and enable all pass the same filter, so they stay aligned
  // provided the user holds address and data steady around the active clock edge.
  assign pins_raw.rclk = read_clk;
  assign pins_raw.wclk = write_clk;
  assign pins_raw.rd.addr = read_addr;
  assign pins_raw.wr.en = write_en;
  assign pins_raw.wr.addr = write_addr;
  assign pins_raw.wr.data = write_data_in;

  dpsb_sync #(
    .WIDTH(dpsb_pkg::PINS_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(pins_raw),
    .filt_out(pins_f)
  );

  // A port clock is seen only through the three-stage filter, so each of its levels must last at least two
  // system clocks; a shorter pulse is lost without notice, the price of sampling the port clocks as data.
  // An active edge is a change of the filtered clock into the selected level.
  assign rd_fire = (pins_f.rclk != st_r.rclk_prev) && (pins_f.rclk == read_clk_pol);
  assign wr_fire = (pins_f.wclk != st_r.wclk_prev) && (pins_f.wclk == write_clk_pol) && pins_f.wr.en;

  // The organisation select is a configuration level and is not filtered; it must not move while a port is busy.
  // Byte words occupy a pair of nibbles; the top address bit is dropped in that mode.
  always_comb begin
    if (byte_mode) begin
      rd_lo_idx = {pins_f.rd.addr[dpsb_pkg::BYTE_AW-1:0], 1'b0};
      rd_hi_idx = {pins_f.rd.addr[dpsb_pkg::BYTE_AW-1:0], 1'b1};
      wr_lo_idx = {pins_f.wr.addr[dpsb_pkg::BYTE_AW-1:0], 1'b0};
      wr_hi_idx = {pins_f.wr.addr[dpsb_pkg::BYTE_AW-1:0], 1'b1};
      rd_word = {st_r.mem[rd_hi_idx], st_r.mem[rd_lo_idx]};
    end else begin
      rd_lo_idx = pins_f.rd.addr;
      rd_hi_idx = pins_f.rd.addr;
      wr_lo_idx = pins_f.wr.addr;
      wr_hi_idx = pins_f.wr.addr;
      rd_word = {dpsb_pkg::NIB_ZERO, st_r.mem[rd_lo_idx]};
    end
  end

  // A read and a write in the same cycle to the same word return the old contents.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rclk_prev = pins_f.rclk;
    st_nxt.wclk_prev = pins_f.wclk;
    st_nxt.rdone = rd_fire;
    st_nxt.wdone = wr_fire;
    if (rd_fire) begin
      st_nxt.rdata = rd_word;
    end
    if (wr_fire) begin
      st_nxt.mem[wr_lo_idx] = pins_f.wr.data[dpsb_pkg::NIB_W-1:0];
      if (byte_mode) begin
        st_nxt.mem[wr_hi_idx] = pins_f.wr.data[dpsb_pkg::DATA_W-1:dpsb_pkg::NIB_W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign read_data_out = st_r.rdata;
  assign read_done = st_r.rdone;
  assign write_done = st_r.wdone;

  default clocking dpsb_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  rd_present_a: assert property (rd_fire |=> read_done && read_data_out == $past(rd_word))
    else $error("read data not presented after read edge");

  rd_hold_a: assert property (!rd_fire |=> $stable(read_data_out))
    else $error("read data changed without a read edge");

  nib_store_a: assert property (wr_fire && !byte_mode |=>
    st_r.mem[$past(pins_f.wr.addr)] == $past(pins_f.wr.data[3:0]))
    else $error("nibble write not stored");

  byte_store_a: assert property (wr_fire && byte_mode |=>
    {st_r.mem[{$past(pins_f.wr.addr[4:0]), 1'b1}], st_r.mem[{$past(pins_f.wr.addr[4:0]), 1'b0}]}
    == $past(pins_f.wr.data))
    else $error("byte write not stored at low five address bits");

  byte_read_a: assert property (rd_fire && byte_mode |->
    rd_word == {st_r.mem[{pins_f.rd.addr[4:0], 1'b1}], st_r.mem[{pins_f.rd.addr[4:0], 1'b0}]})
    else $error("byte read depends on ignored address bit");

  nib_lanes_a: assert property (rd_fire && !byte_mode |=>
    read_data_out[7:4] == 4'h0 && read_data_out[3:0] == $past(st_r.mem[pins_f.rd.addr]))
    else $error("nibble read wrong or upper lanes not zero");

  pol_edge_a: assert property (rd_fire |-> pins_f.rclk == read_clk_pol && $past(pins_f.rclk) != read_clk_pol)
    else $error("read fired on the wrong clock polarity");

  wr_clk_a: assert property (write_done |-> $past(pins_f.wclk) == write_clk_pol
    && $past(pins_f.wclk, 2) != write_clk_pol)
    else $error("write happened without its own clock edge");

  indep_ports_a: assert property (rd_fire && wr_fire |=> read_done && write_done)
    else $error("simultaneous read and write not both served");

  wr_nib_c: cover property (wr_fire && !byte_mode);
  wr_byte_c: cover property (wr_fire && byte_mode);
  rd_byte_c: cover property (rd_fire && byte_mode);
  both_c: cover property (rd_fire && wr_fire);
  rd_nib_c: cover property (rd_fire && !byte_mode);

  // Each port on its own: no answer appears without its active edge, and a pulse lasts one cycle.
  rd_quiet_a: assert property (!rd_fire |=> !read_done)
    else $error("read done without a read edge");

  rd_pulse_a: assert property (read_done |=> !read_done)
    else $error("read done longer than one cycle");

  wr_done_a: assert property (wr_fire |=> write_done)
    else $error("write edge not acknowledged");

  wr_quiet_a: assert property (!wr_fire |=> !write_done && st_r.mem == $past(st_r.mem))
    else $error("memory changed without an enabled write edge");

  wr_pulse_a: assert property (write_done |=> !write_done)
    else $error("write done longer than one cycle");

  // A nibble write must leave its byte partner alone, or the two organisations would disagree.
  nib_keep_a: assert property (wr_fire && !byte_mode |=>
    st_r.mem[$past(pins_f.wr.addr) ^ 6'h01] == $past(st_r.mem[pins_f.wr.addr ^ 6'h01]))
    else $error("nibble write disturbed its neighbour");

  // The filter is a fixed delay for any input that holds still; these tie the internal view to the pins.
  rd_addr_filt_a: assert property ($stable(read_addr) [*6] |-> pins_f.rd.addr == read_addr)
    else $error("filtered read address does not follow the pin");

  wr_addr_filt_a: assert property ($stable(write_addr) [*6] |-> pins_f.wr.addr == write_addr)
    else $error("filtered write address does not follow the pin");

  wr_data_filt_a: assert property ($stable(write_data_in) [*6] |-> pins_f.wr.data == write_data_in)
    else $error("filtered write data does not follow the pin");

  // The checks below start from the raw pins, so a filter that loses or delays an edge is caught as well
  // as a wrong decode; each antecedent holds the pin level for three cycles, more than the two that the filter needs.
  sequence rd_pin_act_s;
    $changed(read_clk) && read_clk == read_clk_pol ##1 $stable(read_clk) [*3];
  endsequence

  sequence rd_pin_idle_s;
    $changed(read_clk) && read_clk != read_clk_pol ##1 $stable(read_clk) [*3];
  endsequence

  sequence wr_pin_act_s;
    $changed(write_clk) && write_clk == write_clk_pol && write_en ##1 ($stable(write_clk) && write_en) [*3];
  endsequence

  sequence wr_pin_noen_s;
    $changed(write_clk) && write_clk == write_clk_pol && !write_en ##1 ($stable(write_clk) && !write_en) [*3];
  endsequence

  sequence wr_pin_idle_s;
    $changed(write_clk) && write_clk != write_clk_pol ##1 $stable(write_clk) [*3];
  endsequence

  rd_pin_lat_a: assert property (rd_pin_act_s |-> ##[1:3] read_done)
    else $error("read pin edge not answered in time");

  rd_pin_off_a: assert property (rd_pin_idle_s |-> ##1 !read_done [*4])
    else $error("read answered on the inactive clock level");

  wr_pin_lat_a: assert property (wr_pin_act_s |-> ##[1:3] write_done)
    else $error("write pin edge not answered in time");

  wr_pin_noen_a: assert property (wr_pin_noen_s |-> ##1 !write_done [*4])
    else $error("write acknowledged although writing was not requested");

  wr_pin_idle_a: assert property (wr_pin_idle_s |-> ##1 !write_done [*4])
    else $error("write acknowledged on the inactive clock level");

endmodule : dpsb_top

// [sim/dpsb_user.sv]
`timescale 1ns/100ps
module dpsb_user (
  input wire logic sys_clk,
  output logic read_clk,
  output logic write_clk,
  output logic [dpsb_pkg::ADDR_W-1:0] read_addr,
  output logic [dpsb_pkg::ADDR_W-1:0] write_addr,
  output logic [dpsb_pkg::DATA_W-1:0] write_data_in,
  output logic write_en
);
  initial begin
    {read_clk, write_clk, read_addr, write_addr, write_data_in, write_en} = '0;
  end
  task automatic idle(input logic rp, input logic wp);
    read_clk = ~rp;
    write_clk = ~wp;
  endtask : idle
  // One block only, so no extra address bits are decoded here.
  task automatic op(input logic rd, wr, rp, wp, input logic [5:0] ra, wa, input logic [7:0] d, input logic we);
    @(negedge sys_clk);
    read_addr = ra;
    write_addr = wa;
    write_data_in = d;
    write_en = we;
    repeat (5) @(negedge sys_clk);
    if (rd) read_clk = rp;
    if (wr) write_clk = wp;
    repeat (4) @(negedge sys_clk);
    idle(rp, wp);
    // Data is not held past its hold time, so a late store would catch garbage.
    write_data_in = ~d;
    repeat (3) @(negedge sys_clk);
  endtask : op
endmodule : dpsb_user

// [sim/dpsb_top_tb.sv]
`timescale 1ns/100ps
module dpsb_top_tb;
  logic sys_clk, rstn, byte_mode, rpol, wpol, read_clk, write_clk, write_en, read_done, write_done;
  logic [5:0] read_addr, write_addr, a, la;
  logic [7:0] write_data_in, read_data_out, d;
  logic [3:0] mem [64];
  logic [7:0] rd_q[$];
  logic [7:0] wr_q[$];
  int seed = 58;
  int n_errors = 0;
  int checks = 0;
  dpsb_user dpsb_user_inst (.sys_clk(sys_clk), .read_clk(read_clk), .write_clk(write_clk),
    .read_addr(read_addr), .write_addr(write_addr), .write_data_in(write_data_in), .write_en(write_en));
  dpsb_top dpsb_top_inst (.sys_clk(sys_clk), .rstn(rstn), .byte_mode(byte_mode), .read_clk_pol(rpol),
    .write_clk_pol(wpol), .read_clk(read_clk), .write_clk(write_clk), .read_addr(read_addr),
    .write_addr(write_addr), .write_data_in(write_data_in), .write_en(write_en),
    .read_data_out(read_data_out), .read_done(read_done), .write_done(write_done));
  task automatic check(input string name, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Expected read data is taken before the store, so a collision expects old data.
  task automatic do_op(input logic rd, wr, input logic [5:0] ra, wa, input logic [7:0] dd, input logic we);
    if (rd) rd_q.push_back(byte_mode ? {mem[{ra[4:0], 1'h1}], mem[{ra[4:0], 1'h0}]} : {4'h0, mem[ra]});
    if (wr && we) begin
      wr_q.push_back(dd);
      if (byte_mode) {mem[{wa[4:0], 1'h1}], mem[{wa[4:0], 1'h0}]} = dd;
      else mem[wa] = dd[3:0];
    end
    dpsb_user_inst.op(rd, wr, rpol, wpol, ra, wa, dd, we);
  endtask : do_op
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (rstn === 1'h1 && read_done === 1'h1) begin
      check("read_done", {7'h00, rd_q.size() > 0}, 8'h01);
      if (rd_q.size() > 0) check("read_data_out", rd_q.pop_front(), read_data_out);
    end
    if (rstn === 1'h1 && write_done === 1'h1) begin
      check("write_done", {7'h00, wr_q.size() > 0}, 8'h01);
      if (wr_q.size() > 0) wr_q.delete(0);
    end
  end
  initial begin
    {rstn, byte_mode, rpol, wpol} = 4'h3;
    for (int p = 0; p < 2; p++) begin
      @(negedge sys_clk);
      rstn = 1'h0;
      byte_mode = p[0];
      rpol = ~p[0];
      wpol = ~p[0];
      dpsb_user_inst.idle(rpol, wpol);
      foreach (mem[i]) mem[i] = 4'h0;
      repeat (5) @(negedge sys_clk);
      rstn = 1'h1;
      for (int k = 0; k < 24; k++) begin
        a = $random(seed);
        d = $random(seed);
        case (k % 4)
          0: do_op(1'h0, 1'h1, a, a, d, 1'h1);
          1: do_op(1'h1, 1'h0, la ^ {byte_mode, 5'h00}, a, d, 1'h0);
          2: do_op(1'h1, 1'h1, a, a ^ 6'h01, d, 1'h0);
          default: do_op(1'h1, 1'h1, a ^ 6'h01, a, d, 1'h1);
        endcase
        if (k % 4 == 0 || k % 4 == 3) la = a;
      end
      for (int t = 0; t < 20 && rd_q.size() + wr_q.size() > 0; t++) @(negedge sys_clk);
      check("queues_empty", 8'(rd_q.size() + wr_q.size()), 8'h00);
    end
    print_verdict();
  end
endmodule : dpsb_top_tb
